//--- include/usb_audio_mix_defines.svh
// constants for the two-input usb audio ring buffer mixer
`ifndef USB_AUDIO_MIX_DEFINES_SVH
`define USB_AUDIO_MIX_DEFINES_SVH

// ==========================================================
// timing
// ==========================================================
`define CLK_FREQ_MHZ      50
`define FRAME_TIME_US     1000
`define UFRAME_TIME_US    125
`define FRAME_CYCLES      (`FRAME_TIME_US * `CLK_FREQ_MHZ)
`define UFRAME_CYCLES     (`UFRAME_TIME_US * `CLK_FREQ_MHZ)

// ==========================================================
// buffer and packet sizes, in bytes
// ==========================================================
`define RING_BYTES        3072
`define BYTES_PER_WORD    4
`define PKT_BYTES_UAC1    192
`define PKT_BYTES_UAC2    96

// ==========================================================
// register offsets
// ==========================================================
`define OFS_CTRL          8'h00
`define OFS_STATUS        8'h04
`define OFS_FILL0         8'h08
`define OFS_FILL1         8'h0C
`define OFS_SOF_STAMP     8'h10
`define OFS_SOF_PERIOD    8'h14
`define OFS_FRAC_DIV      8'h18

// ==========================================================
// field positions and reset values
// ==========================================================
`define CTRL_MODE_BIT     0
`define CTRL_START_LSB    4
`define CTRL_START_MSB    6
`define START_PKTS_RESET  3'h4
`define START_PKTS_MIN    3'h2
`define FRAC_DIV_RESET    16'h8000
`define FRAC_DIV_STEP     16'h0001

`endif

//--- include/usb_audio_mix_pkg.sv
// types shared by the usb audio mixer design
package usb_audio_mix_pkg;
   typedef enum logic {XFER_WAIT, XFER_RUN} xfer_state_e;
   typedef logic [11:0] fill_t;    // byte count within one ring
   typedef logic [9:0]  ptr_t;     // word index within one ring
   typedef logic [15:0] sample_t;  // one signed audio sample
endpackage : usb_audio_mix_pkg

//--- logic/two_entry_buffer.sv
// two-entry valid/ready buffer for the mixed output stream
`timescale 1ns/100ps
module two_entry_buffer #(
   parameter int WIDTH = 33
) (
   input  logic             ref_clk,
   input  logic             rst,
   input  logic             inValid,
   output logic             inReady,
   input  logic [WIDTH-1:0] inData,
   output logic             outValid,
   input  logic             outReady,
   output logic [WIDTH-1:0] outData
);

   // ==========================================================
   // storage and handshake
   // ==========================================================
   logic [WIDTH-1:0] headReg;   // entry shown at the output
   logic [WIDTH-1:0] tailReg;   // second entry behind the head
   logic [1:0]       countReg;  // entries held, 0 to 2
   wire              push = inValid & inReady;
   wire              pop  = outValid & outReady;

   assign inReady  = (countReg != 2'h2);
   assign outValid = (countReg != 2'h0);
   assign outData  = headReg;

   // entry count, push and pop may coincide
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         countReg <= 2'h0;
      end else if (push && !pop) begin
         countReg <= countReg + 2'h1;
      end else if (pop && !push) begin
         countReg <= countReg - 2'h1;
      end
   end

   // head loads new data or moves the tail forward
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         headReg <= '0;
         tailReg <= '0;
      end else begin
         if (push && (countReg == 2'h0 || (countReg == 2'h1 && pop))) begin
            headReg <= inData;
         end else if (pop && countReg == 2'h2) begin
            headReg <= tailReg;
         end
         if (push && countReg == 2'h1 && !pop) begin
            tailReg <= inData;
         end
      end
   end

endmodule : two_entry_buffer

//--- logic/usb_audio_mix_ring_start.sv
// two-input audio ring buffers, start threshold, mixer and sof tracking
// Functional notes
// - sof events timestamped by capture timer
// - each off-nominal sof after the first adjusts audio fractional divider
// - one transfer moves one packet, 192 bytes at full speed, 96 in class 2.0 mode
// - input starts at four transfer lengths filled
// - activation counts inputs, first raises ready
// - default full speed packet 192 bytes per 1 ms
// - configured threshold never below two packets
// - next transfer follows completion without gap
// - packet debug pin toggles per packet
// - transfer debug pin toggles at start, end
// - each input owns a 3072 byte ring
// - both inputs mixed into output buffer
`timescale 1ns/100ps
`include "usb_audio_mix_defines.svh"
module usb_audio_mix_ring_start
   import usb_audio_mix_pkg::*;
#(
   parameter int FRAME_CYCLES  = `FRAME_CYCLES,
   parameter int UFRAME_CYCLES = `UFRAME_CYCLES,
   parameter int TIMER_W       = 16,
   parameter int DIV_W         = 16
) (
   input  logic               ref_clk,
   input  logic               rst,
   // apb slave
   input  logic [7:0]         paddr,
   input  logic               psel,
   input  logic               penable,
   input  logic               pwrite,
   input  logic [31:0]        pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // received packet words, left sample high, right low
   input  logic               pktValid,
   output logic               pktReady,
   input  logic [31:0]        pktData,
   input  logic               pktSpeaker,
   input  logic               pktLast,
   // start of frame marker
   input  logic               sofPulse,
   // mixed stream toward the i2s transmit queue
   output logic               outValid,
   input  logic               outReady,
   output logic [31:0]        outData,
   output logic               outLast,
   // audio clock synthesiser and debug
   output logic [DIV_W-1:0]   audioFracDiv,
   output logic               mixerReadyNotify,
   output logic               packetDebugPin,
   output logic               transferDebugPin
);

   // ==========================================================
   // constants
   // ==========================================================
   localparam int RING_WORDS = `RING_BYTES / `BYTES_PER_WORD;
   localparam ptr_t PTR_LAST = ptr_t'(RING_WORDS - 1);
   localparam logic [12:0] RING_LIMIT = 13'(`RING_BYTES);
   localparam logic [TIMER_W-1:0] FRAME_NOM = TIMER_W'(FRAME_CYCLES);
   localparam logic [TIMER_W-1:0] UFRAME_NOM = TIMER_W'(UFRAME_CYCLES);

   // ==========================================================
   // state
   // ==========================================================
   logic                 ctrlModeReg;          // 1 selects class 2.0
   logic [2:0]           startPktsReg;         // threshold in packets
   fill_t                bufferFillCount [2];  // bytes held per ring
   ptr_t                 wrPtrReg [2];         // next word written
   ptr_t                 rdPtrReg [2];         // next word mixed
   fill_t                pktBytesReg;          // bytes of open packet
   logic [1:0]           inputActiveFlag;      // rings supplying output
   logic [1:0]           activeInputCount;     // number of active rings
   logic [1:0]           useMaskReg;           // rings in this transfer
   xfer_state_e          stateReg;             // transfer engine state
   logic [5:0]           wordCntReg;           // word within transfer
   logic [TIMER_W-1:0]   timerReg;             // free capture timer
   logic [TIMER_W-1:0]   sofStampReg;          // timer at last sof
   logic [TIMER_W-1:0]   sofPeriodReg;         // last sof spacing
   logic                 sofSeenReg;           // a stamp is held
   logic [DIV_W-1:0]     fracDivReg;           // synthesiser divider
   logic [31:0]          prdataReg;            // read data, set in setup
   logic                 slvErrReg;            // unmapped, set in setup
   logic                 pktDbgReg;            // packet debug level
   logic                 xferDbgReg;           // transfer debug level
   logic [31:0]          ringMem [2][RING_WORDS]; // both rings

   // ==========================================================
   // transfer size and start level
   // ==========================================================
   wire fill_t transferSizeValue = ctrlModeReg ?
      fill_t'(`PKT_BYTES_UAC2) : fill_t'(`PKT_BYTES_UAC1);
   wire [5:0] lastWord = transferSizeValue[7:2] - 6'h01;
   wire fill_t startLevel = fill_t'(transferSizeValue *
      fill_t'(startPktsReg));

   // ==========================================================
   // packet intake
   // ==========================================================
   wire fill_t curFill = bufferFillCount[pktSpeaker];
   wire [12:0] roomNeed = {1'b0, curFill} + {1'b0, pktBytesReg}
      + 13'(`BYTES_PER_WORD);
   wire pktFire = pktValid & pktReady;
   wire pktEnd = pktFire & pktLast;
   wire fill_t payload = pktBytesReg + fill_t'(`BYTES_PER_WORD);

   // refuse a word that would overrun the bytes not yet mixed
   assign pktReady = (roomNeed <= RING_LIMIT);

   // ==========================================================
   // activation
   // ==========================================================
   wire [1:0] crossing;
   assign crossing[0] = !inputActiveFlag[0] &&
      (bufferFillCount[0] >= startLevel);
   assign crossing[1] = !inputActiveFlag[1] &&
      (bufferFillCount[1] >= startLevel);
   wire [1:0] countNext = activeInputCount + {1'b0, crossing[0]}
      + {1'b0, crossing[1]};

   // ==========================================================
   // transfer engine and mixer
   // ==========================================================
   wire [1:0] dataOk;
   assign dataOk[0] = !inputActiveFlag[0] ||
      (bufferFillCount[0] >= transferSizeValue);
   assign dataOk[1] = !inputActiveFlag[1] ||
      (bufferFillCount[1] >= transferSizeValue);
   wire firstWord = (wordCntReg == 6'h00);
   wire [1:0] mixMask = firstWord ? inputActiveFlag : useMaskReg;
   wire pushValid = (stateReg == XFER_RUN) &&
      (!firstWord || (dataOk == 2'h3));
   wire bufInReady;
   wire pushFire = pushValid & bufInReady;
   wire xferStart = pushFire & firstWord;
   wire xferDone = pushFire & (wordCntReg == lastWord);
   wire [31:0] word0 = mixMask[0] ? ringMem[0][rdPtrReg[0]] : 32'h0;
   wire [31:0] word1 = mixMask[1] ? ringMem[1][rdPtrReg[1]] : 32'h0;

   // saturating sum of two signed samples
   function automatic sample_t sat_add(input sample_t a,
                                       input sample_t b);
      logic signed [16:0] s;
      s = $signed({a[15], a}) + $signed({b[15], b});
      if (s > 17'sh0_7FFF) begin
         sat_add = 16'h7FFF;
      end else if (s < -17'sh0_8000) begin
         sat_add = 16'h8000;
      end else begin
         sat_add = s[15:0];
      end
   endfunction : sat_add

   wire [31:0] mixWord = {sat_add(word0[31:16], word1[31:16]),
                          sat_add(word0[15:0], word1[15:0])};

   // output buffer between mixer and transmit queue
   two_entry_buffer #(
      .WIDTH    (33)
   ) u_out_buffer (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .inValid  (pushValid),
      .inReady  (bufInReady),
      .inData   ({xferDone, mixWord}),
      .outValid (outValid),
      .outReady (outReady),
      .outData  ({outLast, outData})
   );

   // ==========================================================
   // apb decode
   // ==========================================================
   wire apbSetup = psel & !penable;
   wire apbWrite = psel & penable & pwrite;
   wire hitCtrl = (paddr == `OFS_CTRL);
   wire hitDiv = (paddr == `OFS_FRAC_DIV);
   wire addrHit = hitCtrl || hitDiv || (paddr == `OFS_STATUS) ||
      (paddr == `OFS_FILL0) || (paddr == `OFS_FILL1) ||
      (paddr == `OFS_SOF_STAMP) || (paddr == `OFS_SOF_PERIOD);
   wire [2:0] startWr = pwdata[`CTRL_START_MSB:`CTRL_START_LSB];
   wire [2:0] startClamped = (startWr < `START_PKTS_MIN) ?
      `START_PKTS_MIN : startWr;
   wire [31:0] ctrlWord = {25'h0, startPktsReg, 3'h0, ctrlModeReg};
   wire [31:0] statusWord = {26'h0, (stateReg == XFER_RUN),
      mixerReadyNotify, activeInputCount, inputActiveFlag};
   wire [31:0] readMux =
      hitCtrl                      ? ctrlWord :
      (paddr == `OFS_STATUS)       ? statusWord :
      (paddr == `OFS_FILL0)        ? {20'h0, bufferFillCount[0]} :
      (paddr == `OFS_FILL1)        ? {20'h0, bufferFillCount[1]} :
      (paddr == `OFS_SOF_STAMP)    ? 32'(sofStampReg) :
      (paddr == `OFS_SOF_PERIOD)   ? 32'(sofPeriodReg) :
      hitDiv                       ? 32'(fracDivReg) : 32'h0;

   assign pready = 1'b1;
   assign prdata = prdataReg;
   assign pslverr = slvErrReg & psel & penable;

   // read data and error latched during the setup cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdataReg <= 32'h0;
         slvErrReg <= 1'b0;
      end else if (apbSetup) begin
         prdataReg <= readMux;
         slvErrReg <= !addrHit;
      end
   end

   // control register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrlModeReg  <= 1'b0;
         startPktsReg <= `START_PKTS_RESET;
      end else if (apbWrite && hitCtrl) begin
         ctrlModeReg  <= pwdata[`CTRL_MODE_BIT];
         startPktsReg <= startClamped;
      end
   end

   // ==========================================================
   // sof capture and divider tracking
   // ==========================================================
   wire [TIMER_W-1:0] nominal = ctrlModeReg ? UFRAME_NOM :
      FRAME_NOM;
   wire [TIMER_W-1:0] measured = timerReg - sofStampReg;

   // free timer and stamp of each sof
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         timerReg     <= '0;
         sofStampReg  <= '0;
         sofPeriodReg <= '0;
         sofSeenReg   <= 1'b0;
      end else begin
         timerReg <= timerReg + 1'b1;
         if (sofPulse) begin
            sofStampReg  <= timerReg;
            sofPeriodReg <= measured;
            sofSeenReg   <= 1'b1;
         end
      end
   end

   // slow host frames lower the divider, fast ones raise it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fracDivReg <= DIV_W'(`FRAC_DIV_RESET);
      end else if (sofPulse && sofSeenReg && measured > nominal) begin
         fracDivReg <= fracDivReg - DIV_W'(`FRAC_DIV_STEP);
      end else if (sofPulse && sofSeenReg && measured < nominal) begin
         fracDivReg <= fracDivReg + DIV_W'(`FRAC_DIV_STEP);
      end else if (apbWrite && hitDiv) begin
         fracDivReg <= pwdata[DIV_W-1:0];
      end
   end

   assign audioFracDiv = fracDivReg;

   // ==========================================================
   // ring writes
   // ==========================================================
   // payload words land at each ring's write pointer
   always_ff @(posedge ref_clk) begin
      if (pktFire) begin
         ringMem[pktSpeaker][wrPtrReg[pktSpeaker]] <= pktData;
      end
   end

   // packet byte count, closed by the last word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pktBytesReg <= '0;
      end else if (pktEnd) begin
         pktBytesReg <= '0;
      end else if (pktFire) begin
         pktBytesReg <= payload;
      end
   end

   // ==========================================================
   // per-ring pointers and fill counts
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            wrPtrReg[i]        <= '0;
            rdPtrReg[i]        <= '0;
            bufferFillCount[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (pktFire && (pktSpeaker == i[0])) begin
               wrPtrReg[i] <= (wrPtrReg[i] == PTR_LAST) ? '0 :
                  wrPtrReg[i] + 1'b1;
            end
            if (pushFire && mixMask[i]) begin
               rdPtrReg[i] <= (rdPtrReg[i] == PTR_LAST) ? '0 :
                  rdPtrReg[i] + 1'b1;
            end
            bufferFillCount[i] <= bufferFillCount[i]
               + ((pktEnd && pktSpeaker == i[0]) ? payload : '0)
               - ((xferDone && mixMask[i]) ?
                  transferSizeValue : '0);
         end
      end
   end

   // ==========================================================
   // activation and ready
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inputActiveFlag  <= 2'h0;
         activeInputCount <= 2'h0;
         mixerReadyNotify <= 1'b0;
      end else begin
         inputActiveFlag  <= inputActiveFlag | crossing;
         activeInputCount <= countNext;
         if (activeInputCount == 2'h0 && countNext != 2'h0) begin
            mixerReadyNotify <= 1'b1;
         end
      end
   end

   // ==========================================================
   // transfer sequencing
   // ==========================================================
   // waits for the first active ring, then streams packets
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stateReg   <= XFER_WAIT;
         wordCntReg <= 6'h00;
         useMaskReg <= 2'h0;
      end else begin
         case (stateReg)
            XFER_WAIT: begin
               if (mixerReadyNotify) begin
                  stateReg <= XFER_RUN;
               end
            end
            XFER_RUN: begin
               if (xferStart) begin
                  useMaskReg <= inputActiveFlag;
               end
               if (xferDone) begin
                  wordCntReg <= 6'h00;
               end else if (pushFire) begin
                  wordCntReg <= wordCntReg + 6'h01;
               end
            end
            default: begin
               stateReg <= XFER_WAIT;
            end
         endcase
      end
   end

   // ==========================================================
   // latency debug pins
   // ==========================================================
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pktDbgReg  <= 1'b0;
         xferDbgReg <= 1'b0;
      end else begin
         if (pktEnd) begin
            pktDbgReg <= !pktDbgReg;
         end
         if (xferStart || xferDone) begin
            xferDbgReg <= !xferDbgReg;
         end
      end
   end

   assign packetDebugPin   = pktDbgReg;
   assign transferDebugPin = xferDbgReg;

endmodule : usb_audio_mix_ring_start

//--- testbench/usb_audio_mix_ring_start_chk.sv
// concurrent checks on the audio mixer ports
`timescale 1ns/100ps
module usb_audio_mix_ring_start_chk #(
   parameter int DIV_W = 16
) (
   input logic             ref_clk,
   input logic             rst,
   input logic [7:0]       paddr,
   input logic             psel,
   input logic             penable,
   input logic             pwrite,
   input logic [31:0]      prdata,
   input logic             pready,
   input logic             pslverr,
   input logic             pktValid,
   input logic             pktReady,
   input logic             pktLast,
   input logic             outValid,
   input logic             outReady,
   input logic             outLast,
   input logic [DIV_W-1:0] audioFracDiv,
   input logic             mixerReadyNotify,
   input logic             packetDebugPin
);
   // ======================================================
   // words taken in this transfer
   logic [5:0] wordCnt;  // word position
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wordCnt <= 6'h00;
      end else if (outValid && outReady) begin
         wordCnt <= outLast ? 6'h00 : wordCnt + 6'h01;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_pready_high: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   chk_slverr_gate: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   chk_unmapped_err: assert property (psel && penable && paddr > 8'h18
      |-> pslverr) else $error("unmapped without error");
   chk_unmapped_zero: assert property (psel && penable && !pwrite &&
      pslverr |-> prdata == 32'h0000_0000) else $error("unmapped read");
   chk_pkt_toggle: assert property (
      $changed(packetDebugPin) == $past(pktValid && pktReady && pktLast))
      else $error("packet pin out of step");
   chk_div_step: assert property ($changed(audioFracDiv) &&
      !$past(psel && penable && pwrite && paddr == 8'h18) |->
      (audioFracDiv - $past(audioFracDiv)) inside {DIV_W'(1),
      {DIV_W{1'b1}}}) else $error("divider step too big");
   chk_ready_sticky: assert property (!$fell(mixerReadyNotify))
      else $error("mixer ready dropped");
   chk_no_early: assert property (outValid |-> mixerReadyNotify)
      else $error("output before active input");
   chk_out_hold: assert property (outValid && !outReady |=> outValid &&
      $stable(outLast)) else $error("stalled word not held");
   chk_xfer_len: assert property (outValid && outReady &&
      outLast |-> wordCnt == 6'h2F || wordCnt == 6'h17)
      else $error("transfer length wrong");
   cover property (outValid && outReady && outLast);
   cover property (pktValid && pktReady && pktLast);
   cover property ($rose(mixerReadyNotify));
endmodule : usb_audio_mix_ring_start_chk
bind usb_audio_mix_ring_start usb_audio_mix_ring_start_chk #(
   .DIV_W(DIV_W)
) u_chk (
   .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pktValid(pktValid),
   .pktReady(pktReady), .pktLast(pktLast), .outValid(outValid),
   .outReady(outReady), .outLast(outLast),
   .audioFracDiv(audioFracDiv), .mixerReadyNotify(mixerReadyNotify),
   .packetDebugPin(packetDebugPin)
);

//--- testbench/usb_host_model.sv
// usb host model: packet words and frame markers
`timescale 1ns/100ps
module usb_host_model #(
   parameter int FRAME = 200
) (
   input  logic        ref_clk,
   input  logic        pktReady,
   output logic        pktValid = 1'b0,
   output logic [31:0] pktData = '0,
   output logic        pktSpeaker = 1'b0,
   output logic        pktLast = 1'b0,
   output logic        sofPulse = 1'b0
);
   // one packet per frame, words held until taken
   task automatic send(input logic spk, input int n, input logic [31:0] w);
      int t = 0;
      @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         pktValid <= 1'b1;
         pktData <= w;
         pktSpeaker <= spk;
         pktLast <= (i == n - 1);
         @(posedge ref_clk);
         t++;
         while (!pktReady) begin
            @(posedge ref_clk);
            t++;
         end
      end
      // released bus shows the inverse
      pktValid <= 1'b0;
      pktLast <= 1'b0;
      pktData <= ~w;
      repeat (FRAME - t) @(posedge ref_clk);
   endtask : send
   // one-cycle sof, next one gap cycles later
   task automatic sof(input int gap);
      @(posedge ref_clk);
      sofPulse <= 1'b1;
      @(posedge ref_clk);
      sofPulse <= 1'b0;
      repeat (gap - 2) @(posedge ref_clk);
   endtask : sof
endmodule : usb_host_model

//--- testbench/usb_audio_mix_ring_start_tb.sv
// self-checking bench for the audio mixer
`timescale 1ns/100ps
`include "usb_audio_mix_defines.svh"
`define CHECK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module usb_audio_mix_ring_start_tb import usb_audio_mix_pkg::*;;
   // ======================================================
   // stimulus and observed signals
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        outReady = 1'b0;
   logic [31:0] prdata, outData, pktData, rdv;
   logic        pready, pslverr, pktValid, pktReady, pktSpeaker, pktLast;
   logic        sofPulse, outValid, outLast, mixerReadyNotify, lastErr;
   logic        packetDebugPin, transferDebugPin;
   logic [15:0] audioFracDiv;
   int          fails = 0, checks = 0, cycles = 0, tdCnt = 0;
   usb_audio_mix_ring_start #(.FRAME_CYCLES(200), .UFRAME_CYCLES(50)) u_dut (
      .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pktValid(pktValid),
      .pktReady(pktReady), .pktData(pktData), .pktSpeaker(pktSpeaker),
      .pktLast(pktLast), .sofPulse(sofPulse), .outValid(outValid),
      .outReady(outReady), .outData(outData), .outLast(outLast),
      .audioFracDiv(audioFracDiv), .mixerReadyNotify(mixerReadyNotify),
      .packetDebugPin(packetDebugPin), .transferDebugPin(transferDebugPin));
   usb_host_model u_host (.ref_clk(ref_clk),
      .pktReady(pktReady), .pktValid(pktValid), .pktData(pktData),
      .pktSpeaker(pktSpeaker), .pktLast(pktLast), .sofPulse(sofPulse));
   always #10 ref_clk = ~ref_clk;
   // transfer pin edges after reset
   always @(transferDebugPin) if (!rst) tdCnt++;
   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // one apb transfer, result in rdv and lastErr
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d = 32'h0);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (!pready) @(posedge ref_clk);
      rdv = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // take n words, each expected to be w
   task automatic drain(input int n, input int tl, input logic [31:0] w);
      int k = 0;
      int gaps = 0;
      @(posedge ref_clk);
      outReady <= 1'b1;
      while (k < n) begin
         @(posedge ref_clk);
         if (outValid) begin
            `CHECK("word", w, outData)
            `CHECK("last", k % tl == tl - 1, outLast)
            k++;
         end else if (k > 0) begin
            gaps++;
         end
      end
      outReady <= 1'b0;
      `CHECK("gaps", 0, gaps)
   endtask : drain
   task automatic t_regs;
      apb(1'b0, `OFS_CTRL);
      `CHECK("ctrl", 32'h0000_0040, rdv)
      apb(1'b1, `OFS_CTRL, 32'h0000_0010);
      apb(1'b0, `OFS_CTRL);
      `CHECK("ctrl_min", 32'h0000_0020, rdv)
      apb(1'b1, `OFS_CTRL, 32'h0000_0040);
      apb(1'b0, 8'h1C);
      `CHECK("unmapped", 33'h0_0000_0001, {rdv, lastErr})
   endtask : t_regs
   task automatic t_sof;
      u_host.sof(210);
      u_host.sof(190);
      `CHECK("div_slow", 16'h7FFF, audioFracDiv)
      u_host.sof(5);
      apb(1'b0, `OFS_SOF_PERIOD);
      `CHECK("period", 32'h0000_00BE, rdv)
      `CHECK("div_fast", 16'h8000, audioFracDiv)
   endtask : t_sof
   task automatic t_start;
      repeat (3) u_host.send(1'b0, 48, 32'h1234_0F0F);
      `CHECK("early", 2'b00, {outValid, mixerReadyNotify})
      u_host.send(1'b0, 48, 32'h1234_0F0F);
      apb(1'b0, `OFS_FILL0);
      `CHECK("fill0", 32'h0000_0300, rdv)
      apb(1'b0, `OFS_STATUS);
      `CHECK("status", 32'h0000_0015, rdv & 32'h0000_001F)
      drain(192, 48, 32'h1234_0F0F);
      apb(1'b0, `OFS_FILL0);
      `CHECK("fill0_empty", 32'h0000_0000, rdv)
   endtask : t_start
   task automatic t_mix;
      repeat (4) u_host.send(1'b1, 48, 32'h7000_9000);
      apb(1'b0, `OFS_STATUS);
      `CHECK("status2", 32'h0000_001B, rdv & 32'h0000_001F)
      `CHECK("wait_both", 1'b0, outValid)
      u_host.send(1'b0, 48, 32'h7000_9000);
      drain(48, 48, 32'h7FFF_8000);
      apb(1'b0, `OFS_FILL1);
      `CHECK("fill1", 32'h0000_0240, rdv)
   endtask : t_mix
   task automatic t_mode;
      apb(1'b1, `OFS_CTRL, 32'h0000_0041);
      u_host.send(1'b0, 24, 32'h0001_0002);
      drain(24, 24, 32'h7001_9002);
      apb(1'b0, `OFS_FILL1);
      `CHECK("fill1_hs", 32'h0000_01E0, rdv)
      `CHECK("xfer_pin", 12, tdCnt)
   endtask : t_mode
   // ======================================================
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_sof();
      t_start();
      t_mix();
      t_mode();
      report_and_stop();
   end
endmodule : usb_audio_mix_ring_start_tb
